/* File: core/ipwm_width_meas.sv */
`default_nettype none
module ipwm_width_meas
   import ipwm_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // timer input pin and interrupt
   input wire logic timer_input_pin,
   output logic channel_interrupt
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic presc_tick(input logic [15:0] cnt, input logic [3:0] sel);
      logic [15:0] mask;
      mask = 16'((17'h1 << sel) - 17'h1);
      return (cnt & mask) == mask;
   endfunction

   function automatic logic known_addr(input logic [7:0] a);
      return a inside {OFS_PERIPH_EN, OFS_PRESCALE, OFS_MODE, OFS_NOISE, OFS_OUTPUT,
                       OFS_TRIGGER, OFS_ENABLED, OFS_COUNTER, OFS_CAPTURE, OFS_STATUS};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake state
   logic aw_free_r, aw_free_nxt, w_free_r, w_free_nxt;
   logic arready_r, arready_nxt;
   logic [7:0] aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0] w_strb_r, w_strb_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic wr_fire, rd_fire;

   // timer and register state
   logic unit_en_r, unit_en_nxt;
   logic [15:0] presc_sel_r, presc_sel_nxt;
   ipwm_mode_t mode_r, mode_nxt;
   logic noise_en_r, noise_en_nxt;
   ipwm_out_t out_r, out_nxt;
   logic enabled_r, enabled_nxt;
   ipwm_state_t state_r, state_nxt;
   logic [15:0] div_r, div_nxt;
   logic [15:0] count_r, count_nxt;
   logic [15:0] capture_r, capture_nxt;
   logic ovf_r, ovf_nxt;
   logic wrapped_r, wrapped_nxt;
   logic irq_r, irq_nxt;
   logic [2:0] pin_sync_r;
   logic pin_lvl_r, pin_lvl_nxt;
   logic smp_r, smp_nxt;
   logic filt_r, filt_nxt;

   ////////////////////////////////////////////////////////////////////////////
   assign wr_fire = !aw_free_r && !w_free_r && !bvalid_r;
   assign rd_fire = s_axi_arvalid && !rvalid_r;

   always_comb begin
      aw_free_nxt = aw_free_r;
      w_free_nxt = w_free_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_awvalid && aw_free_r) begin
         aw_free_nxt = 1'b0;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && w_free_r) begin
         w_free_nxt = 1'b0;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (wr_fire) begin
         aw_free_nxt = 1'b1;
         w_free_nxt = 1'b1;
         bvalid_nxt = 1'b1;
         bresp_nxt = known_addr(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (rd_fire) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         rdata_nxt = 32'h0000_0000;
         unique case (s_axi_araddr)
            OFS_PERIPH_EN: rdata_nxt[POS_UNIT_EN] = unit_en_r;
            OFS_PRESCALE: rdata_nxt[15:0] = presc_sel_r;
            OFS_MODE: begin
               rdata_nxt[POS_CLK_SEL +: 2] = mode_r.clk_sel;
               rdata_nxt[POS_EDGE_SEL +: 2] = mode_r.edge_sel;
               rdata_nxt[POS_OP_MODE +: 3] = mode_r.op_mode;
            end
            OFS_NOISE: rdata_nxt[POS_NOISE] = noise_en_r;
            OFS_OUTPUT: rdata_nxt[3:0] = out_r;
            OFS_ENABLED: rdata_nxt[0] = enabled_r;
            OFS_COUNTER: rdata_nxt[15:0] = count_r;
            OFS_CAPTURE: rdata_nxt[15:0] = capture_r;
            OFS_STATUS: rdata_nxt[POS_OVF] = ovf_r;
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_free_r <= 1'b1;
         w_free_r <= 1'b1;
         arready_r <= 1'b1;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else begin
         aw_free_r <= aw_free_nxt;
         w_free_r <= w_free_nxt;
         arready_r <= arready_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_axi_awready = aw_free_r;
   assign s_axi_wready = w_free_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser: first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_sync_r <= 3'h0;
      end else begin
         pin_sync_r <= {pin_sync_r[1:0], timer_input_pin};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic op_tick, unit_wr, meas_mode;
   logic edge_rise, edge_fall, start_edge, capt_edge;

   always_comb begin
      unit_en_nxt = unit_en_r;
      presc_sel_nxt = presc_sel_r;
      mode_nxt = mode_r;
      noise_en_nxt = noise_en_r;
      out_nxt = out_r;
      enabled_nxt = enabled_r;
      state_nxt = state_r;
      div_nxt = div_r;
      count_nxt = count_r;
      capture_nxt = capture_r;
      ovf_nxt = ovf_r;
      wrapped_nxt = wrapped_r;
      irq_nxt = 1'b0;
      pin_lvl_nxt = pin_lvl_r;
      smp_nxt = smp_r;
      filt_nxt = filt_r;
      edge_rise = 1'b0;
      edge_fall = 1'b0;
      // writes other than the unit enable ignored while the unit is off
      unit_wr = wr_fire && unit_en_r && w_strb_r[0];
      // only capture one-count mode measures widths
      // edge select picks low or high width
      meas_mode = (mode_r.op_mode == MODE_CAPT_ONE) && mode_r.edge_sel[1];
      // four prescaled clocks; the mode picks one
      op_tick = presc_tick(div_r, presc_sel_r[{mode_r.clk_sel, 2'b00} +: POS_PRESC_W]);
      if (pin_sync_r[1] == pin_sync_r[2]) begin
         pin_lvl_nxt = pin_sync_r[2];
      end
      // prescaler cleared to zero while the unit is off
      // divider runs once the unit is enabled
      div_nxt = unit_en_r ? div_r + 16'h0001 : 16'h0000;
      // sample on operation clock, optional filter
      if (unit_en_r && op_tick) begin
         smp_nxt = pin_lvl_r;
         if (!noise_en_r || smp_r == pin_lvl_r) begin
            filt_nxt = pin_lvl_r;
            edge_rise = pin_lvl_r && !filt_r;
            edge_fall = !pin_lvl_r && filt_r;
         end
      end
      start_edge = (mode_r.edge_sel == EDGE_HIGH_W) ? edge_rise : edge_fall;
      capt_edge = (mode_r.edge_sel == EDGE_HIGH_W) ? edge_fall : edge_rise;
      unique case (state_r)
         ST_STOPPED: begin
         end
         ST_WAIT_START: begin
            if (meas_mode && start_edge) begin
               count_nxt = RST_COUNT;
               wrapped_nxt = 1'b0;
               state_nxt = ST_COUNTING;
            end
         end
         ST_COUNTING: begin
            if (op_tick) begin
               count_nxt = count_r + 16'h0001;
               if (count_r == COUNT_FULL) begin
                  wrapped_nxt = 1'b1;
               end
               if (capt_edge) begin
                  capture_nxt = count_r;
                  irq_nxt = 1'b1;
                  ovf_nxt = wrapped_r;
                  // hold until the next start edge
                  state_nxt = ST_WAIT_START;
               end
            end
         end
      endcase
      if (unit_wr) begin
         unique case (aw_addr_r)
            OFS_PRESCALE: presc_sel_nxt = w_data_r[15:0];
            OFS_MODE: begin
               mode_nxt.clk_sel = w_data_r[POS_CLK_SEL +: 2];
               mode_nxt.edge_sel = w_data_r[POS_EDGE_SEL +: 2];
               mode_nxt.op_mode = w_data_r[POS_OP_MODE +: 3];
            end
            OFS_NOISE: noise_en_nxt = w_data_r[POS_NOISE];
            OFS_OUTPUT: out_nxt = w_data_r[3:0];
            OFS_TRIGGER: begin
               // counter and overflow flag are held
               if (w_data_r[POS_STOP]) begin
                  enabled_nxt = 1'b0;
                  state_nxt = ST_STOPPED;
               // start: enabled, wait for start edge
               end else if (w_data_r[POS_START] && !enabled_r) begin
                  enabled_nxt = 1'b1;
                  state_nxt = ST_WAIT_START;
               end
            end
            default: begin
            end
         endcase
      end
      if (wr_fire && w_strb_r[0] && aw_addr_r == OFS_PERIPH_EN) begin
         unit_en_nxt = w_data_r[POS_UNIT_EN];
      end
      // unit off returns the timer registers to reset; the filter takes the pin level
      if (!unit_en_r) begin
         presc_sel_nxt = RST_PRESCALE;
         mode_nxt = RST_MODE;
         noise_en_nxt = 1'b0;
         out_nxt = RST_OUT;
         enabled_nxt = 1'b0;
         state_nxt = ST_STOPPED;
         count_nxt = RST_COUNT;
         capture_nxt = RST_CAPTURE;
         ovf_nxt = 1'b0;
         wrapped_nxt = 1'b0;
         smp_nxt = 1'b0;
         filt_nxt = pin_lvl_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unit_en_r <= 1'b0;
         presc_sel_r <= RST_PRESCALE;
         mode_r <= RST_MODE;
         noise_en_r <= 1'b0;
         out_r <= RST_OUT;
         enabled_r <= 1'b0;
         state_r <= ST_STOPPED;
         div_r <= 16'h0000;
         count_r <= RST_COUNT;
         capture_r <= RST_CAPTURE;
         ovf_r <= 1'b0;
         wrapped_r <= 1'b0;
         irq_r <= 1'b0;
         pin_lvl_r <= 1'b0;
         smp_r <= 1'b0;
         filt_r <= 1'b0;
      end else begin
         unit_en_r <= unit_en_nxt;
         presc_sel_r <= presc_sel_nxt;
         mode_r <= mode_nxt;
         noise_en_r <= noise_en_nxt;
         out_r <= out_nxt;
         enabled_r <= enabled_nxt;
         state_r <= state_nxt;
         div_r <= div_nxt;
         count_r <= count_nxt;
         capture_r <= capture_nxt;
         ovf_r <= ovf_nxt;
         wrapped_r <= wrapped_nxt;
         irq_r <= irq_nxt;
         pin_lvl_r <= pin_lvl_nxt;
         smp_r <= smp_nxt;
         filt_r <= filt_nxt;
      end
   end

   assign channel_interrupt = irq_r;
endmodule
`default_nettype wire

/* File: core/ipwm_pkg.sv */
`default_nettype none
package ipwm_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_PERIPH_EN = 8'h00;
   localparam logic [7:0] OFS_PRESCALE = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;
   localparam logic [7:0] OFS_NOISE = 8'h0C;
   localparam logic [7:0] OFS_OUTPUT = 8'h10;
   localparam logic [7:0] OFS_TRIGGER = 8'h14;
   localparam logic [7:0] OFS_ENABLED = 8'h18;
   localparam logic [7:0] OFS_COUNTER = 8'h1C;
   localparam logic [7:0] OFS_CAPTURE = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   // field positions
   localparam int POS_UNIT_EN = 0;
   localparam int POS_START = 0;
   localparam int POS_STOP = 1;
   localparam int POS_OVF = 0;
   localparam int POS_NOISE = 0;
   localparam int POS_CLK_SEL = 14;
   localparam int POS_EDGE_SEL = 6;
   localparam int POS_OP_MODE = 1;
   localparam int POS_PRESC_W = 4;
   // encodings
   localparam logic [2:0] MODE_CAPT_ONE = 3'h6;
   localparam logic [1:0] EDGE_LOW_W = 2'h2;
   localparam logic [1:0] EDGE_HIGH_W = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // values after reset, and the full count
   localparam logic [15:0] RST_PRESCALE = 16'h0000;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [15:0] RST_CAPTURE = 16'h0000;
   localparam logic [15:0] COUNT_FULL = 16'hFFFF;

   typedef struct packed {
      logic [1:0] clk_sel;
      logic [1:0] edge_sel;
      logic [2:0] op_mode;
   } ipwm_mode_t;

   typedef struct packed {
      logic enable;
      logic value;
      logic mode;
      logic level;
   } ipwm_out_t;

   localparam ipwm_mode_t RST_MODE = '{clk_sel: 2'h0, edge_sel: 2'h0, op_mode: 3'h0};
   localparam ipwm_out_t RST_OUT = '{enable: 1'h0, value: 1'h0, mode: 1'h0, level: 1'h0};

   typedef enum logic [1:0] {
      ST_STOPPED,
      ST_WAIT_START,
      ST_COUNTING
   } ipwm_state_t;
endpackage
`default_nettype wire

/* File: tb/ipwm_pulse_src.sv */
`default_nettype none
module ipwm_pulse_src (
   // clock
   input wire logic aclk,
   // pulse request
   input wire logic go,
   input wire logic idle_hi,
   input wire logic [16:0] plen,
   // measured signal
   output var logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [16:0] left_r = 17'h0;
   always_ff @(posedge aclk) begin
      if (go) begin
         left_r <= plen;
      end else if (left_r != 17'h0) begin
         left_r <= left_r - 17'h1;
      end
   end
   // the pulse is the opposite of the idle level, exactly plen cycles long
   assign pin = (left_r != 17'h0) ? !idle_hi : idle_hi;
endmodule
`default_nettype wire

/* File: tb/ipwm_props.sv */
`default_nettype none
module ipwm_props
   import ipwm_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrupt
   input wire logic channel_interrupt
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic ar_take;
   logic wr_take;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   ////////////////////////////////////////
   irq_one_cycle_a: assert property (channel_interrupt |=> !channel_interrupt)
      else $error("interrupt wider than one cycle");
   read_answer_a: assert property (ar_take |=> s_axi_rvalid)
      else $error("read not answered");
   read_okay_a: assert property (ar_take && s_axi_araddr <= OFS_STATUS && s_axi_araddr[1:0] == 2'h0 |=>
      s_axi_rresp == RESP_OKAY) else $error("mapped read refused");
   read_unmapped_a: assert property (ar_take && s_axi_araddr > OFS_STATUS |=> s_axi_rresp == RESP_SLVERR)
      else $error("unmapped read accepted");
   trig_reads_zero_a: assert property (ar_take && s_axi_araddr == OFS_TRIGGER |=> s_axi_rdata == 32'h0)
      else $error("trigger read not zero");
   flag_bit_only_a: assert property (ar_take && (s_axi_araddr == OFS_STATUS || s_axi_araddr == OFS_ENABLED)
      |=> s_axi_rdata[31:1] == 31'h0) else $error("flag read has upper bits");
   write_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   irq_seen_c: cover property (channel_interrupt);
   bad_read_c: cover property (ar_take && s_axi_araddr > OFS_STATUS);
   write_c: cover property (wr_take);
endmodule
`default_nettype wire

/* File: tb/input_pulse_width_measurement_bench.sv */
`default_nettype none
module input_pulse_width_measurement_bench
   import ipwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic timer_input_pin, channel_interrupt;
   logic aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, go = 1'h0, idle_hi = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [16:0] plen = 17'h0;
   int n_mismatch = 0;
   int samples_checked = 0;
   ipwm_width_meas i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .timer_input_pin, .channel_interrupt);
   ipwm_pulse_src i_src (.aclk, .go, .idle_hi, .plen, .pin(timer_input_pin));
   initial begin
      aclk = 1'h0;
      forever #20 aclk = ~aclk;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic hang(input int i, input int lim);
      if (i >= lim) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) break;
      end
      rr = s_axi_bresp;
      s_axi_bready <= 1'h0;
      hang(i, 50);
   endtask
   task automatic rd(input logic [7:0] a);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) break;
      end
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'h0;
      hang(i, 50);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rv, e);
   endtask
   function automatic logic [31:0] md(input logic [1:0] c, input logic [1:0] e);
      return {16'h0, c, 6'h0, e, 2'h0, MODE_CAPT_ONE, 1'h0};
   endfunction
   // stop, set up, arm, send one pulse, write start again mid-pulse (ignored while enabled), then judge the capture
   task automatic measure(input logic [31:0] m, input logic nf, input logic ih, input logic [16:0] len,
      input logic [31:0] cap, input logic ovf);
      logic [31:0] cnt;
      logic [31:0] st;
      int i;
      rd(OFS_COUNTER);
      cnt = rv;
      rd(OFS_STATUS);
      st = rv;
      wr(OFS_TRIGGER, 32'h2);
      rc(OFS_ENABLED, 32'h0);
      rc(OFS_COUNTER, cnt);
      rc(OFS_STATUS, st);
      wr(OFS_MODE, m);
      wr(OFS_NOISE, {31'h0, nf});
      idle_hi <= ih;
      repeat (8) @(posedge aclk);
      wr(OFS_TRIGGER, 32'h1);
      rc(OFS_ENABLED, 32'h1);
      rc(OFS_TRIGGER, 32'h0);
      plen <= len;
      go <= 1'h1;
      @(posedge aclk);
      go <= 1'h0;
      repeat (len / 2) @(posedge aclk);
      rd(OFS_COUNTER);
      chk(rv > 32'h0 && rv < len, 32'h1);
      wr(OFS_TRIGGER, 32'h1);
      for (i = 0; i < 70000 && channel_interrupt !== 1'h1; i++) @(posedge aclk);
      hang(i, 70000);
      rd(OFS_CAPTURE);
      chk(rv + 32'h1 >= cap && rv <= cap + 32'h1, 32'h1);
      cnt = rv + 32'h1;
      rc(OFS_STATUS, {31'h0, ovf});
      rc(OFS_COUNTER, cnt);
   endtask
   // stop mid-pulse: the count freezes, no capture follows, the flag keeps its value
   task automatic stop_midway();
      logic [31:0] c;
      logic seen;
      int i;
      seen = 1'h0;
      plen <= 17'h000C8;
      go <= 1'h1;
      @(posedge aclk);
      go <= 1'h0;
      repeat (60) @(posedge aclk);
      wr(OFS_TRIGGER, 32'h2);
      rd(OFS_COUNTER);
      c = rv;
      chk(rv > 32'h0 && rv < 32'hC8, 32'h1);
      for (i = 0; i < 200; i++) begin
         @(posedge aclk);
         if (channel_interrupt === 1'h1) seen = 1'h1;
      end
      chk({31'h0, seen}, 32'h0);
      rc(OFS_COUNTER, c);
      rc(OFS_ENABLED, 32'h0);
      rc(OFS_STATUS, 32'h1);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      wr(OFS_PERIPH_EN, 32'h1);
      rc(OFS_ENABLED, 32'h0);
      rd(8'h28);
      chk(rr, RESP_SLVERR);
      wr(8'h30, 32'h1);
      chk(rr, RESP_SLVERR);
      wr(OFS_PRESCALE, 32'h10);
      chk(rr, RESP_OKAY);
      rc(OFS_PRESCALE, 32'h10);
      wr(OFS_OUTPUT, 32'h0);
      measure(md(2'h0, EDGE_HIGH_W), 1'h0, 1'h0, 17'h00032, 32'h31, 1'h0);
      measure(md(2'h1, EDGE_HIGH_W), 1'h0, 1'h0, 17'h00028, 32'h13, 1'h0);
      measure(md(2'h0, EDGE_LOW_W), 1'h1, 1'h1, 17'h0001E, 32'h1D, 1'h0);
      measure(md(2'h0, EDGE_HIGH_W), 1'h0, 1'h0, 17'h101D0, 32'h1CF, 1'h1);
      stop_midway();
      measure(md(2'h0, EDGE_HIGH_W), 1'h0, 1'h0, 17'h00014, 32'h13, 1'h0);
      wr(OFS_PERIPH_EN, 32'h0);
      wr(OFS_MODE, md(2'h1, EDGE_LOW_W));
      rc(OFS_MODE, 32'h0);
      rc(OFS_COUNTER, 32'h0);
      rc(OFS_CAPTURE, 32'h0);
      rc(OFS_PRESCALE, 32'h0);
      tally_and_finish();
   end
endmodule
bind ipwm_width_meas ipwm_props i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_interrupt);
`default_nettype wire
